// ==== include/irrp_params.svh ====
// Purpose: Constants shared by both ends of the I2C register read port
// Assumes: 25 MHz system clock on both ends
// Notes: Counts are rounded up to whole clocks
`ifndef IRRP_PARAMS_SVH
`define IRRP_PARAMS_SVH

// ==========================================================
// Register map limits
`define IRRP_RX_HOLD_ADDR 8'h00
`define IRRP_REG_LAST 8'h1F

// ==========================================================
// Target address straps
`define IRRP_STRAP_GND 2'h0
`define IRRP_STRAP_VL 2'h1
`define IRRP_STRAP_SCL 2'h2
`define IRRP_STRAP_SDA 2'h3
`define IRRP_ADDR_BASE 7'h60
`define IRRP_ADDR_GND_GND 7'h6C
`define IRRP_STRAP_SDA_GND 4'hC

// ==========================================================
// Timing
`define IRRP_CLK_NS 40
`define IRRP_SCL_QUARTER_NS 160
`define IRRP_QUARTER_CYC ((`IRRP_SCL_QUARTER_NS + `IRRP_CLK_NS - 1) / `IRRP_CLK_NS)

`endif

// ==== include/irrp_pkg.sv ====
// Purpose: Types for the I2C register read port
// Assumes: Nothing beyond SystemVerilog
// Notes: Each end keeps all its state in one struct
`default_nettype none

package irrp_pkg;

    // ==========================================================
    // Target side
    typedef enum logic [2:0] {T_IDLE, T_ADDR, T_AACK, T_REG, T_RACK, T_TX, T_TACK, T_WAIT} irrp_tstate_t;

    typedef struct packed {
        logic scl_m, scl_s, scl_p;
        logic sda_m, sda_s, sda_p;
        logic [1:0] strap0_m, strap0_s, strap1_m, strap1_s;
        logic [6:0] addr;
        irrp_tstate_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic acked;
        logic [7:0] ptr;
        logic [7:0] tx;
        logic sda_o, sda_oe, irq_o, irq_oe;
        logic strobe;
    } irrp_tgt_t;

    // ==========================================================
    // Host side
    typedef enum logic [1:0] {M_IDLE, M_START, M_BYTE, M_STOP} irrp_mstate_t;
    typedef enum logic [1:0] {K_AW, K_REG, K_AR, K_DATA} irrp_stage_t;

    typedef struct packed {
        logic sda_m, sda_s, irq_m, irq_s;
        irrp_mstate_t st;
        irrp_stage_t stage;
        logic [1:0] q;
        logic [3:0] tmr;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic [7:0] left;
        logic [6:0] dev;
        logic [7:0] reg_addr;
        logic scl_o, scl_oe, sda_o, sda_oe;
        logic busy, done, err, rd_valid, irq_active;
        logic [7:0] rd_data;
    } irrp_mst_t;

endpackage

`default_nettype wire

// ==== include/irrp_if.sv ====
// Purpose: Two-wire link plus interrupt line between host and target
// Assumes: Open-drain wires with pull-ups
// Notes: Wire levels are resolved here from the enables
`default_nettype none

interface irrp_if;
    logic scl_o_m, scl_oe_m, sda_o_m, sda_oe_m;
    logic sda_o_t, sda_oe_t, irq_o_t, irq_oe_t;
    logic scl, sda, irq_n;

    // ==========================================================
    // Wired-AND resolution, pulled high when released
    assign scl = !(scl_oe_m && !scl_o_m);
    assign sda = !(sda_oe_m && !sda_o_m) && !(sda_oe_t && !sda_o_t);
    assign irq_n = !(irq_oe_t && !irq_o_t);

    modport target (input scl, sda, output sda_o_t, sda_oe_t, irq_o_t, irq_oe_t);
    modport host (input scl, sda, irq_n, output scl_o_m, scl_oe_m, sda_o_m, sda_oe_m);
endinterface

`default_nettype wire

// ==== design/irrp_master.sv ====
// Purpose: Host end, reads N registers from the target
// Assumes: Target does not stretch the clock
// Notes: SCL period is four quarters of the divider
`include "irrp_params.svh"
`default_nettype none

module irrp_master import irrp_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    irrp_if.host link,
    input wire logic go,
    input wire logic [6:0] dev_addr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] rd_count,
    output logic busy,
    output logic done,
    output logic err,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic irq_active
);
    irrp_mst_t r, n;
    logic tick, tx_stage, acked;

    // ==========================================================
    // Next-state logic
    always_comb begin
        n = r;
        tick = (r.tmr == 4'h0);
        tx_stage = (r.stage != K_DATA);
        acked = !r.sda_s;
        n.sda_m = link.sda;
        n.sda_s = r.sda_m;
        // Interrupt seen by the host, for interrupt-driven readiness
        n.irq_m = link.irq_n;
        n.irq_s = r.irq_m;
        n.irq_active = !r.irq_s; // R11
        n.rd_valid = 1'b0;
        n.done = 1'b0;
        n.tmr = tick ? 4'(`IRRP_QUARTER_CYC - 1) : r.tmr - 4'h1;
        if (tick) begin
            n.q = r.q + 2'h1;
        end
        if (r.st == M_IDLE) begin
            if (go) begin
                n.dev = dev_addr;
                n.reg_addr = reg_addr;
                n.left = (rd_count == 8'h00) ? 8'h01 : rd_count;
                n.sh = {dev_addr, 1'b0}; // R1
                n.stage = K_AW;
                n.st = M_START;
                n.q = 2'h0;
                n.tmr = 4'(`IRRP_QUARTER_CYC - 1);
                n.busy = 1'b1;
                n.err = 1'b0;
            end
        end else if (tick) begin
            // End of a unit
            if (r.q == 2'h3) begin
                case (r.st)
                    M_START: begin
                        n.st = M_BYTE;
                        n.bitn = 4'h0;
                    end
                    M_BYTE: begin
                        if (r.bitn != 4'h8) begin
                            n.sh = tx_stage ? {r.sh[6:0], 1'b0} : {r.sh[6:0], r.sda_s};
                            n.bitn = r.bitn + 4'h1;
                        end else begin
                            n.bitn = 4'h0;
                            case (r.stage)
                                K_AW: begin
                                    n.stage = K_REG;
                                    n.sh = r.reg_addr; // R1
                                end
                                K_REG: begin
                                    n.st = M_START; // R3
                                    n.stage = K_AR;
                                    n.sh = {r.dev, 1'b1}; // R3
                                end
                                K_AR: n.stage = K_DATA;
                                default: begin
                                    n.rd_data = r.sh;
                                    n.rd_valid = 1'b1;
                                    n.left = r.left - 8'h01;
                                    if (r.left == 8'h01) begin
                                        n.st = M_STOP; // R5 R6
                                    end
                                end
                            endcase
                            // NACK to address or register aborts with STOP
                            if (r.stage != K_DATA && !acked) begin
                                n.err = 1'b1; // R10
                                n.st = M_STOP;
                            end
                        end
                    end
                    default: begin
                        n.st = M_IDLE;
                        n.busy = 1'b0;
                        n.done = 1'b1;
                    end
                endcase
            end
            // Quarter actions
            case (n.st)
                M_START: begin
                    case (n.q)
                        2'h0: begin
                            n.sda_oe = 1'b0;
                            n.scl_oe = (n.stage == K_AR);
                        end
                        2'h1: n.scl_oe = 1'b0;
                        2'h2: n.sda_oe = 1'b1;
                        default: n.scl_oe = 1'b1;
                    endcase
                end
                M_BYTE: begin
                    if (n.q == 2'h0) begin
                        n.scl_oe = 1'b1;
                        if (n.bitn != 4'h8) begin
                            // Stage of the unit now starting decides who drives
                            n.sda_oe = (n.stage != K_DATA) && !n.sh[7];
                        end else begin
                            n.sda_oe = !tx_stage && (n.left > 8'h01); // R6 R7 R9
                        end
                    end else if (n.q == 2'h2) begin
                        n.scl_oe = 1'b0;
                    end
                end
                M_STOP: begin
                    case (n.q)
                        2'h0: begin
                            n.scl_oe = 1'b1;
                            n.sda_oe = 1'b1;
                        end
                        2'h1: n.scl_oe = 1'b0;
                        2'h2: n.sda_oe = 1'b0; // R5
                        default: n.sda_oe = 1'b0;
                    endcase
                end
                default: begin
                    n.scl_oe = 1'b0;
                    n.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            // Synchronisers start at the idle level of their pins
            r.sda_m <= 1'b1;
            r.sda_s <= 1'b1;
            r.irq_m <= 1'b1;
            r.irq_s <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from the state register
    assign link.scl_o_m = r.scl_o;
    assign link.scl_oe_m = r.scl_oe;
    assign link.sda_o_m = r.sda_o;
    assign link.sda_oe_m = r.sda_oe;
    assign busy = r.busy;
    assign done = r.done;
    assign err = r.err;
    assign rd_data = r.rd_data;
    assign rd_valid = r.rd_valid;
    assign irq_active = r.irq_active;
endmodule // irrp_master

`default_nettype wire

// ==== design/irrp_target.sv ====
// Purpose: Target end of the I2C register read port
// Assumes: SCL and SDA are asynchronous pins, sampled by clk
// Notes: Write data after the register byte is ignored
//
// Function
// R1: Master sends START, address+write, register byte
// R2: Acknowledge register byte only when address valid
// R3: Master then sends repeated START, address+read
// R4: Acknowledge read address, shift out eight bits
// R5: Single read ends with master NACK, STOP
// R6: Burst: master ACKs all but last byte
// R7: Keep sending while the master acknowledges
// R8: Pointer increments per byte, except at 0x00
// R9: ACK drives data low over ninth pulse
// R10: NACK leaves data released over ninth pulse
// R11: Host waits for interrupt release after reset
// R12: Polled host rereads known register until expected
// R13: Polled host ignores interrupt pin, polls status
// R14: Drive open-drain interrupt low on events
// R15: Two four-level straps pick one of sixteen addresses
// R16: Register 0x00 reads pop the receive queue
// R17: After master NACK release, await STOP/START
`include "irrp_params.svh"
`default_nettype none

module irrp_target import irrp_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    irrp_if.target link,
    input wire logic [1:0] addr_strap_0,
    input wire logic [1:0] addr_strap_1,
    input wire logic irq_req,
    output logic [7:0] reg_rd_addr,
    input wire logic [7:0] reg_rd_data,
    output logic reg_rd_strobe,
    output logic [6:0] own_addr
);
    irrp_tgt_t r, n;
    logic rise, fall, start_seen, stop_seen;

    // ==========================================================
    // Helpers

    // Strap levels to 7-bit target address
    function automatic logic [6:0] strap_addr(input logic [1:0] a1, input logic [1:0] a0);
        logic [3:0] code;
        code = {a1, a0};
        if (code == 4'h0) begin
            strap_addr = `IRRP_ADDR_GND_GND;
        end else if (code == `IRRP_STRAP_SDA_GND) begin
            strap_addr = `IRRP_ADDR_BASE;
        end else begin
            strap_addr = `IRRP_ADDR_BASE | {3'h0, code};
        end
    endfunction

    // Register addresses that answer a read
    function automatic logic reg_valid(input logic [7:0] a);
        reg_valid = (a <= `IRRP_REG_LAST);
    endfunction

    // ==========================================================
    // Bus event detection on the synchronised pins
    always_comb begin
        rise = r.scl_s && !r.scl_p;
        fall = !r.scl_s && r.scl_p;
        start_seen = r.scl_s && r.scl_p && r.sda_p && !r.sda_s;
        stop_seen = r.scl_s && r.scl_p && !r.sda_p && r.sda_s;
    end

    // ==========================================================
    // Next-state logic
    always_comb begin
        n = r;
        // Two-flop synchronisers, then an edge-detect stage
        n.scl_m = link.scl;
        n.scl_s = r.scl_m;
        n.scl_p = r.scl_s;
        n.sda_m = link.sda;
        n.sda_s = r.sda_m;
        n.sda_p = r.sda_s;
        n.strap0_m = addr_strap_0;
        n.strap0_s = r.strap0_m;
        n.strap1_m = addr_strap_1;
        n.strap1_s = r.strap1_m;
        n.addr = strap_addr(r.strap1_s, r.strap0_s); // R15
        // Interrupt pin follows the event request
        n.irq_o = 1'b0;
        n.irq_oe = irq_req; // R14
        n.sda_o = 1'b0;
        n.strobe = 1'b0;

        if (stop_seen) begin
            n.st = T_IDLE;
            n.sda_oe = 1'b0;
        end else if (start_seen) begin
            // START or repeated START restarts address reception
            n.st = T_ADDR;
            n.cnt = 4'h0;
            n.sda_oe = 1'b0;
        end else begin
            case (r.st)
                T_IDLE, T_WAIT: begin
                    n.sda_oe = 1'b0; // R17
                end
                T_ADDR, T_REG: begin
                    if (rise && r.cnt != 4'h8) begin
                        n.sh = {r.sh[6:0], r.sda_s};
                        n.cnt = r.cnt + 4'h1;
                    end else if (fall && r.cnt == 4'h8) begin
                        if (r.st == T_ADDR) begin
                            if (r.sh[7:1] == r.addr) begin
                                n.rw = r.sh[0];
                                n.sda_oe = 1'b1; // R4 R9
                                n.st = T_AACK;
                            end else begin
                                n.st = T_IDLE;
                            end
                        end else if (reg_valid(r.sh)) begin
                            n.ptr = r.sh;
                            n.sda_oe = 1'b1; // R2 R9
                            n.st = T_RACK;
                        end else begin
                            n.sda_oe = 1'b0; // R2 R10
                            n.st = T_WAIT;
                        end
                    end
                end
                T_AACK: begin
                    if (fall) begin
                        n.cnt = 4'h0;
                        if (r.rw) begin
                            // First byte fetched at the selected pointer
                            n.tx = reg_rd_data; // R4
                            n.strobe = 1'b1; // R16
                            n.sda_oe = !reg_rd_data[7];
                            n.st = T_TX;
                        end else begin
                            n.sda_oe = 1'b0;
                            n.st = T_REG;
                        end
                    end
                end
                T_RACK: begin
                    // Register byte taken, await repeated START
                    if (fall) begin
                        n.sda_oe = 1'b0;
                        n.st = T_WAIT;
                    end
                end
                T_TX: begin
                    if (rise) begin
                        n.cnt = r.cnt + 4'h1;
                    end else if (fall) begin
                        if (r.cnt == 4'h8) begin
                            n.sda_oe = 1'b0; // R10
                            n.st = T_TACK;
                        end else begin
                            n.tx = {r.tx[6:0], 1'b0};
                            n.sda_oe = !r.tx[6]; // R4
                        end
                    end
                end
                T_TACK: begin
                    if (rise) begin
                        // Master answer sampled on the ninth rise
                        n.acked = !r.sda_s; // R9 R10
                        if (!r.sda_s && r.ptr != `IRRP_RX_HOLD_ADDR) begin
                            n.ptr = r.ptr + 8'h01; // R8
                        end
                    end else if (fall) begin
                        n.cnt = 4'h0;
                        if (r.acked) begin
                            n.tx = reg_rd_data; // R7
                            n.strobe = 1'b1; // R16
                            n.sda_oe = !reg_rd_data[7];
                            n.st = T_TX;
                        end else begin
                            n.sda_oe = 1'b0; // R17
                            n.st = T_WAIT;
                        end
                    end
                end
                default: begin
                    n.st = T_IDLE;
                    n.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            // Pin synchronisers start at the released level, no false edge
            r.scl_m <= 1'b1;
            r.scl_s <= 1'b1;
            r.scl_p <= 1'b1;
            r.sda_m <= 1'b1;
            r.sda_s <= 1'b1;
            r.sda_p <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ==========================================================
    // Outputs straight from the state register
    assign link.sda_o_t = r.sda_o;
    assign link.sda_oe_t = r.sda_oe;
    assign link.irq_o_t = r.irq_o;
    assign link.irq_oe_t = r.irq_oe;
    assign reg_rd_addr = r.ptr;
    assign reg_rd_strobe = r.strobe;
    assign own_addr = r.addr;
endmodule // irrp_target

`default_nettype wire

// ==== dv/irrp_link_assertions.sv ====
// Purpose: Protocol checks on the two-wire link between host and target
// Assumes: Both ends run from one clk; released lines are pulled high
// Notes: Bit and byte position are tracked from START and SCL rises
`default_nettype none

module irrp_link_assertions (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_oe_m,
    input wire logic sda_oe_t
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // Bit position tracking
    logic scl_q, sda_q, rw, nacked;
    logic [3:0] cnt;
    logic [7:0] bidx;
    logic rise, start, txph;
    logic [3:0] bitno;
    logic [7:0] byte_no;

    // Edge, START and position decode
    assign rise = scl && !scl_q;
    assign start = scl && scl_q && sda_q && !sda;
    assign bitno = (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
    assign byte_no = (cnt == 4'h9) ? bidx + 8'h01 : bidx;
    assign txph = rw && (byte_no != 8'h00);

    // Counters restart at every START or repeated START
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            cnt <= 4'h0;
            bidx <= 8'h00;
            rw <= 1'b0;
            nacked <= 1'b0;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (start) begin
                cnt <= 4'h0;
                bidx <= 8'h00;
                rw <= 1'b0;
                nacked <= 1'b0;
            end else if (rise) begin
                cnt <= bitno;
                bidx <= byte_no;
                if (bitno == 4'h8 && byte_no == 8'h00) rw <= sda;
                if (bitno == 4'h9 && txph && sda) nacked <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Assertions
    idle_after_reset_a: assert property ($rose(rst_n) |-> (scl && sda && !sda_oe_t) [*3])
        else $error("link not idle after reset");
    tgt_change_low_a: assert property ($changed(sda_oe_t) |-> !scl)
        else $error("target moved data line while clock high");
    scl_high_phase_a: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high phase too short");
    scl_low_phase_a: assert property ($fell(scl) |-> !scl [*4])
        else $error("clock low phase too short");
    host_quiet_tx_a: assert property (rise && txph && !nacked && bitno != 4'h9 |-> !sda_oe_m)
        else $error("host drove data line during read data bit");
    tgt_quiet_ack_a: assert property (rise && txph && bitno == 4'h9 |-> !sda_oe_t)
        else $error("target drove data line in host acknowledge slot");
    tgt_quiet_wr_a: assert property (rise && !txph && bitno != 4'h9 |-> !sda_oe_t)
        else $error("target drove data line during host byte");
    nack_release_a: assert property (nacked |-> !sda_oe_t)
        else $error("target drove data line after host refusal");
    tgt_ack_held_a: assert property (rise && bitno == 4'h9 && sda_oe_t |-> sda_oe_t [*8])
        else $error("target acknowledge not held over high phase");

    // Main scenarios reached
    host_ack_c: cover property (rise && txph && bitno == 4'h9 && !sda);
    host_nack_c: cover property (rise && txph && bitno == 4'h9 && sda);
    tgt_ack_c: cover property (rise && !txph && bitno == 4'h9 && sda_oe_t);
endmodule // irrp_link_assertions

`default_nettype wire

// ==== dv/tb.sv ====
// Purpose: Self-checking bench joining host and target ends
// Assumes: Target register file modelled here as address xor A5
// Notes: Register 0x00 is a counting receive queue popped on strobe
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Signals and model state
    localparam int LIMIT = 30000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic go = 1'b0;
    logic [6:0] dev_addr = 7'h00;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] rd_count = 8'h01;
    logic [1:0] addr_strap_0 = 2'h1;
    logic [1:0] addr_strap_1 = 2'h0;
    logic irq_req = 1'b0;
    logic [7:0] rxq = 8'h30;
    logic [7:0] reg_rd_addr, reg_rd_data, rd_data;
    logic [6:0] own_addr;
    logic reg_rd_strobe, busy, done, err, rd_valid, irq_active;
    logic [7:0] got[$];
    int err_total = 0;
    int check_count = 0;
    int nstb = 0;
    int cyc = 0;

    always #20 clk = ~clk;

    irrp_if link_i();

    irrp_master irrp_master_i (.clk(clk), .rst_n(rst_n), .link(link_i), .go(go), .dev_addr(dev_addr),
        .reg_addr(reg_addr), .rd_count(rd_count), .busy(busy), .done(done), .err(err), .rd_data(rd_data),
        .rd_valid(rd_valid), .irq_active(irq_active));

    irrp_target irrp_target_i (.clk(clk), .rst_n(rst_n), .link(link_i), .addr_strap_0(addr_strap_0),
        .addr_strap_1(addr_strap_1), .irq_req(irq_req), .reg_rd_addr(reg_rd_addr),
        .reg_rd_data(reg_rd_data), .reg_rd_strobe(reg_rd_strobe), .own_addr(own_addr));

    irrp_link_assertions irrp_link_assertions_i (.clk(clk), .rst_n(rst_n), .scl(link_i.scl),
        .sda(link_i.sda), .sda_oe_m(link_i.sda_oe_m), .sda_oe_t(link_i.sda_oe_t));

    // Register file seen by the target
    assign reg_rd_data = (reg_rd_addr == 8'h00) ? rxq : (reg_rd_addr ^ 8'hA5);

    // Collect bytes, pop queue, watch for hangs
    always @(posedge clk) begin
        cyc++;
        if (rd_valid === 1'b1) got.push_back(rd_data);
        if (reg_rd_strobe === 1'b1) begin
            nstb++;
            if (reg_rd_addr === 8'h00) rxq <= rxq + 8'h01;
        end
        if (cyc == LIMIT) begin
            err_total++;
            $display("ERROR timeout expected finish seen hang");
            results();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One host read; bad marks an expected refusal
    task automatic rd(input logic [6:0] dev, input logic [7:0] r, input logic [7:0] n, input logic bad);
        logic [7:0] q0;
        logic [7:0] e;
        int k;
        got.delete();
        nstb = 0;
        q0 = rxq;
        dev_addr = dev;
        reg_addr = r;
        rd_count = n;
        go = 1'b1;
        tick();
        go = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 3000) begin
            tick();
            k++;
        end
        chk("done", 8'h01, {7'h00, done});
        chk("busy", 8'h00, {7'h00, busy});
        chk("err", {7'h00, bad}, {7'h00, err});
        chk("byte count", bad ? 8'h00 : n, 8'(got.size()));
        chk("strobe count", bad ? 8'h00 : n, 8'(nstb));
        for (int i = 0; i < got.size(); i++) begin
            e = (r == 8'h00) ? q0 + 8'(i) : (r + 8'(i)) ^ 8'hA5;
            chk("read byte", e, got[i]);
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_straps();
        logic [7:0] e;
        for (int v = 0; v < 16; v++) begin
            addr_strap_1 = 2'(v >> 2);
            addr_strap_0 = 2'(v);
            repeat (4) tick();
            e = (v == 0) ? 8'h6C : (v == 12) ? 8'h60 : 8'h60 | 8'(v);
            chk("own addr", e, {1'b0, own_addr});
        end
        addr_strap_1 = 2'h0;
        addr_strap_0 = 2'h1;
        repeat (4) tick();
    endtask

    task automatic t_single();
        rd(7'h61, 8'h05, 8'h01, 1'b0);
        rd(7'h61, 8'h1F, 8'h01, 1'b0);
    endtask

    task automatic t_burst();
        rd(7'h61, 8'h1D, 8'h04, 1'b0);
        rd(7'h61, 8'h02, 8'h02, 1'b0);
    endtask

    task automatic t_rxhold();
        rd(7'h61, 8'h00, 8'h03, 1'b0);
        rd(7'h61, 8'h00, 8'h01, 1'b0);
    endtask

    task automatic t_badreg();
        rd(7'h61, 8'h20, 8'h02, 1'b1);
        rd(7'h61, 8'h07, 8'h01, 1'b0);
    endtask

    task automatic t_badaddr();
        rd(7'h62, 8'h05, 8'h01, 1'b1);
        rd(7'h61, 8'h03, 8'h02, 1'b0);
    endtask

    task automatic t_irq();
        int k;
        irq_req = 1'b1;
        k = 0;
        while (irq_active !== 1'b1 && k < 8) begin
            tick();
            k++;
        end
        chk("irq active", 8'h01, {7'h00, irq_active});
        chk("irq line", 8'h00, {7'h00, link_i.irq_n});
        // Polled status read carries on while the line is low
        rd(7'h61, 8'h02, 8'h01, 1'b0);
        irq_req = 1'b0;
        repeat (8) tick();
        chk("irq clear", 8'h00, {7'h00, irq_active});
        chk("irq line high", 8'h01, {7'h00, link_i.irq_n});
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        // Interrupt seen released from the first edge after reset
        tick();
        chk("irq after reset", 8'h00, {7'h00, irq_active});
        rd(7'h61, 8'h01, 8'h01, 1'b0);
        t_straps();
        t_single();
        t_burst();
        t_rxhold();
        t_badreg();
        t_badaddr();
        t_irq();
        results();
    end
endmodule // tb

`default_nettype wire
